// ---- rtl/power_unit.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Write of bit 6 gates system clock and stops internal oscillators.
// - After suspend wake, flags read zero for two system clocks.
// - Wake on enabled rtc fail, rtc alarm, port match or comparator rise.
// - Write of bit 7 removes core regulator power, RAM moves to battery.
// - Digital output pins hold their level throughout sleep.
// - Sleep keeps RAM, registers and program state intact.
// - Comparator sleep wake only honoured in two-cell supply mode.
// - Reset-pin falling edge always wakes; stay awake over 15 us.
// - Enables written as ones in the same write selecting the mode.
// - Flags set on events whether enabled or not, also when awake.
// - Any set flag blocks entry and keeps low-power oscillator on.
// - Bit 5 clears all flags; bits 5 to 7 are write-only.
// - Read-only bit 4 flags a reset-pin glitch or falling edge.
// - Bits 3..0: rtc fail, rtc alarm, port match, comparator.
// - One-cell sleep ties analog supply to battery unless float bit set.
// - Suspend wake restarts clocks and resumes at the next instruction.
module power_unit (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire pwr_wake_pkg::sfr_req_t SFR_REQ,
	output logic [7:0] SFR_RDATA,
	input wire pwr_wake_pkg::wake_events_t WAKE_EVENTS,
	input wire logic TWO_CELL_MODE,
	input wire logic SUPPLY_FLOAT_IN_SLEEP,
	output logic SYS_CLK_GATE,
	output logic OSC_DISABLE,
	output logic LOW_POWER_OSC_EN,
	output logic CORE_REGULATOR_OFF,
	output logic RAM_ON_BATTERY,
	output logic GPIO_HOLD,
	output logic ANALOG_SUPPLY_TO_BATTERY,
	output logic COMPARATOR_POWERED,
	output logic CPU_RESUME,
	output logic [1:0] POWER_MODE
);

	////////////////////////////////////////////////////////////////////////
	// Inputs

	logic [4:0] events_async;
	logic [4:0] events_sync;
	logic [4:0] events_pulse;
	logic [4:0] falling_sel;

	assign events_async = WAKE_EVENTS;
	assign falling_sel = 5'h10;

	// Runs on the free core clock, not the gated system clock
	wake_sync #(.WIDTH(5)) u_sync (
		.CORE_CLK(CORE_CLK),
		.SYS_RST(SYS_RST),
		.async_in(events_async),
		.sync_out(events_sync)
	);

	wake_edge #(.WIDTH(5)) u_edge (
		.CORE_CLK(CORE_CLK),
		.SYS_RST(SYS_RST),
		.level_in(events_sync),
		.falling_sel(falling_sel),
		.pulse_out(events_pulse)
	);

	////////////////////////////////////////////////////////////////////////
	// Register access

	logic hit;
	logic wr_hit;
	logic rd_hit;
	logic clear_req;
	logic enter_req;
	logic sleep_sel;

	assign hit = SFR_REQ.addr == pwr_wake_pkg::POWER_WAKE_CONFIG_ADDR;
	assign wr_hit = SFR_REQ.wr && hit;
	assign rd_hit = SFR_REQ.rd && hit;
	assign clear_req = wr_hit && SFR_REQ.wdata[pwr_wake_pkg::CLEAR_BIT];
	assign sleep_sel = SFR_REQ.wdata[pwr_wake_pkg::SLEEP_BIT];
	assign enter_req = wr_hit && (sleep_sel ||
		SFR_REQ.wdata[pwr_wake_pkg::SUSPEND_BIT]);

	////////////////////////////////////////////////////////////////////////
	// Enables

	logic [3:0] enable_r;
	logic [3:0] enable_nxt;

	// Any write reloads the enables, so each entry carries its own
	always_comb begin
		enable_nxt = enable_r;
		if (wr_hit) begin
			enable_nxt = SFR_REQ.wdata[3:0];
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			enable_r <= pwr_wake_pkg::ENABLE_RESET;
		end else begin
			enable_r <= enable_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flags

	logic [4:0] flag_r;
	logic [4:0] flag_nxt;

	// Event wins over a clear in the same cycle; enable does not matter
	always_comb begin
		flag_nxt = flag_r;
		if (clear_req) begin
			flag_nxt = pwr_wake_pkg::FLAG_RESET;
		end
		flag_nxt = flag_nxt | events_pulse;
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			flag_r <= pwr_wake_pkg::FLAG_RESET;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode state

	pwr_wake_pkg::power_mode_t mode_r;
	pwr_wake_pkg::power_mode_t mode_nxt;
	logic [3:0] wake_hit;
	logic wake;
	logic any_flag;

	// Comparator wake from sleep needs the two-cell supply
	always_comb begin
		wake_hit = enable_r & events_pulse[3:0];
		if (mode_r == pwr_wake_pkg::MODE_SLEEP && !TWO_CELL_MODE) begin
			wake_hit[pwr_wake_pkg::COMPARATOR_BIT] = 1'b0;
		end
	end

	assign wake = (|wake_hit) || events_pulse[4];
	assign any_flag = |flag_r;

	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			pwr_wake_pkg::MODE_NORMAL: begin
				// Entry refused while any flag stands
				if (enter_req && !any_flag) begin
					if (sleep_sel) begin
						mode_nxt = pwr_wake_pkg::MODE_SLEEP;
					end else begin
						mode_nxt = pwr_wake_pkg::MODE_SUSPEND;
					end
				end
			end
			pwr_wake_pkg::MODE_SUSPEND, pwr_wake_pkg::MODE_SLEEP: begin
				if (wake) begin
					mode_nxt = pwr_wake_pkg::MODE_NORMAL;
				end
			end
			default: begin
				mode_nxt = pwr_wake_pkg::MODE_NORMAL;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mode_r <= pwr_wake_pkg::MODE_NORMAL;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Post-suspend flag blanking

	logic [1:0] settle_r;
	logic [1:0] settle_nxt;
	localparam logic [1:0] SETTLE_LOAD = 2'(pwr_wake_pkg::FLAG_SETTLE_CLOCKS);

	always_comb begin
		settle_nxt = settle_r;
		if (mode_r == pwr_wake_pkg::MODE_SUSPEND && wake) begin
			settle_nxt = SETTLE_LOAD;
		end else if (settle_r != 2'h0) begin
			settle_nxt = settle_r - 2'h1;
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			settle_r <= 2'h0;
		end else begin
			settle_r <= settle_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all registered

	logic sleeping;
	logic parked;

	assign sleeping = mode_nxt == pwr_wake_pkg::MODE_SLEEP;
	assign parked = mode_nxt != pwr_wake_pkg::MODE_NORMAL;

	// Mode-select and clear bits read as zero; flags blanked while settling
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			SFR_RDATA <= 8'h00;
		end else if (rd_hit && settle_nxt == 2'h0) begin
			SFR_RDATA <= {3'h0, flag_nxt};
		end else begin
			SFR_RDATA <= 8'h00;
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			SYS_CLK_GATE <= 1'b0;
			OSC_DISABLE <= 1'b0;
			LOW_POWER_OSC_EN <= 1'b1;
			CPU_RESUME <= 1'b0;
			POWER_MODE <= 2'h0;
		end else begin
			SYS_CLK_GATE <= parked;
			OSC_DISABLE <= parked;
			// Slow oscillator only stops once parked with no flag
			LOW_POWER_OSC_EN <= !parked || (|flag_nxt);
			// One pulse; CPU continues at the next instruction
			CPU_RESUME <= parked ? 1'b0 :
				(mode_r != pwr_wake_pkg::MODE_NORMAL);
			POWER_MODE <= mode_nxt;
		end
	end

	// Register and RAM contents are untouched by sleep; only power moves
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			CORE_REGULATOR_OFF <= 1'b0;
			RAM_ON_BATTERY <= 1'b0;
			GPIO_HOLD <= 1'b0;
			ANALOG_SUPPLY_TO_BATTERY <= 1'b0;
			COMPARATOR_POWERED <= 1'b1;
		end else begin
			CORE_REGULATOR_OFF <= sleeping;
			RAM_ON_BATTERY <= sleeping;
			GPIO_HOLD <= sleeping;
			ANALOG_SUPPLY_TO_BATTERY <= sleeping && !TWO_CELL_MODE &&
				!SUPPLY_FLOAT_IN_SLEEP;
			COMPARATOR_POWERED <= !sleeping || TWO_CELL_MODE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	// All checks run on the free core clock and rest during reset
	default clocking chk_clk @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);

	a_entry_blocked: assert property (
		(mode_r == pwr_wake_pkg::MODE_NORMAL && enter_req && any_flag)
		|=> mode_r == pwr_wake_pkg::MODE_NORMAL)
		else $error("entry taken with a flag set");

	a_flag_sticky: assert property (
		events_pulse[2] |=> flag_r[2])
		else $error("event did not set flag");

	a_clear_all: assert property (
		(clear_req && events_pulse == 5'h00) |=> flag_r == 5'h00)
		else $error("clear left a flag");

	a_settle_blank: assert property (
		(mode_r == pwr_wake_pkg::MODE_SUSPEND && wake)
		|=> (SFR_RDATA == 8'h00) [*2])
		else $error("flags visible during settle");

	// Resume pulse rises on the same edge that brings the mode back
	a_pin_wake: assert property (
		(mode_r != pwr_wake_pkg::MODE_NORMAL && events_pulse[4])
		|=> mode_r == pwr_wake_pkg::MODE_NORMAL && CPU_RESUME)
		else $error("reset pin did not wake");

	a_comp_one_cell: assert property (
		(mode_r == pwr_wake_pkg::MODE_SLEEP && !TWO_CELL_MODE &&
		events_pulse == 5'h01) |=> mode_r == pwr_wake_pkg::MODE_SLEEP)
		else $error("comparator woke one-cell sleep");

	a_clock_gated: assert property (
		$rose(mode_r == pwr_wake_pkg::MODE_SUSPEND)
		|-> SYS_CLK_GATE && OSC_DISABLE)
		else $error("suspend without clock gate");

	a_sleep_power: assert property (
		(mode_r == pwr_wake_pkg::MODE_SLEEP) |-> CORE_REGULATOR_OFF && GPIO_HOLD)
		else $error("sleep without power switch");

	c_suspend: cover property (@(posedge CORE_CLK)
		mode_r == pwr_wake_pkg::MODE_SUSPEND ##[1:20] CPU_RESUME);
	c_sleep: cover property (@(posedge CORE_CLK)
		mode_r == pwr_wake_pkg::MODE_SLEEP ##[1:20] CPU_RESUME);
	c_refused: cover property (@(posedge CORE_CLK) enter_req && any_flag);

endmodule : power_unit

// ---- rtl/pwr_wake_pkg.sv ----
package pwr_wake_pkg;

	// Register location on the special-function bus
	localparam logic [7:0] POWER_WAKE_CONFIG_ADDR = 8'hB5;

	// Bit positions of power_wake_config
	localparam int SLEEP_BIT = 7;
	localparam int SUSPEND_BIT = 6;
	localparam int CLEAR_BIT = 5;
	localparam int RESET_PIN_WAKE_BIT = 4;
	localparam int RTC_OSC_FAIL_BIT = 3;
	localparam int RTC_ALARM_BIT = 2;
	localparam int PORT_MATCH_BIT = 1;
	localparam int COMPARATOR_BIT = 0;

	// Reset values
	localparam logic [3:0] ENABLE_RESET = 4'h0;
	localparam logic [4:0] FLAG_RESET = 5'h00;

	// Timing
	localparam int CLOCK_MHZ = 25;
	localparam int FLAG_SETTLE_CLOCKS = 2;
	localparam int RESET_HOLD_NS = 15000;
	localparam int RESET_HOLD_CLOCKS = (RESET_HOLD_NS * CLOCK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_SUSPEND = 2'b01,
		MODE_SLEEP = 2'b10
	} power_mode_t;

	// Wake event bundle: {reset pin, rtc fail, rtc alarm, port match, comp}
	typedef struct packed {
		logic reset_pin;
		logic rtc_osc_fail;
		logic rtc_alarm;
		logic port_match;
		logic comparator;
	} wake_events_t;

	// Special-function register access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

endpackage : pwr_wake_pkg

// ---- rtl/wake_edge.sv ----
`timescale 1ns/1ps
module wake_edge #(
	parameter int WIDTH = 5
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic [WIDTH-1:0] level_in,
	input wire logic [WIDTH-1:0] falling_sel,
	output logic [WIDTH-1:0] pulse_out
);

	logic [WIDTH-1:0] prev_r;
	logic [WIDTH-1:0] pulse_r;

	// Selected lines trigger on falling edges, the rest on rising edges
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			prev_r <= '0;
			pulse_r <= '0;
		end else begin
			prev_r <= level_in;
			pulse_r <= (level_in & ~prev_r & ~falling_sel) |
				(~level_in & prev_r & falling_sel);
		end
	end

	assign pulse_out = pulse_r;

endmodule : wake_edge

// ---- rtl/wake_sync.sv ----
`timescale 1ns/1ps
module wake_sync #(
	parameter int WIDTH = 5
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;

	// Two flops per line; only stage2 is looked at downstream
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			stage1_r <= '0;
			stage2_r <= '0;
		end else begin
			stage1_r <= async_in;
			stage2_r <= stage1_r;
		end
	end

	assign sync_out = stage2_r;

endmodule : wake_sync

// ---- tb/power_unit_tb.sv ----
`timescale 1ns/1ps
module power_unit_tb;
	localparam logic [7:0] ADR = pwr_wake_pkg::POWER_WAKE_CONFIG_ADDR;
	logic clk = 1'b0;
	logic rst = 1'b1;
	pwr_wake_pkg::sfr_req_t req = '0;
	pwr_wake_pkg::wake_events_t ev;
	logic two_cell = 1'b1;
	logic flt = 1'b0;
	logic [7:0] rdata;
	logic [7:0] d;
	logic gate, osc_off, lp_osc, reg_off, ram_bat, hold, ana_bat, cmp_pwr;
	logic resume;
	logic [1:0] mode;
	int err_count = 0;
	int compares = 0;

	// Taken as the system clock, already at divide-by-one and ready
	always #20 clk = ~clk;

	power_unit dut (.CORE_CLK(clk), .SYS_RST(rst), .SFR_REQ(req),
		.SFR_RDATA(rdata), .WAKE_EVENTS(ev), .TWO_CELL_MODE(two_cell),
		.SUPPLY_FLOAT_IN_SLEEP(flt), .SYS_CLK_GATE(gate),
		.OSC_DISABLE(osc_off), .LOW_POWER_OSC_EN(lp_osc),
		.CORE_REGULATOR_OFF(reg_off), .RAM_ON_BATTERY(ram_bat),
		.GPIO_HOLD(hold), .ANALOG_SUPPLY_TO_BATTERY(ana_bat),
		.COMPARATOR_POWERED(cmp_pwr), .CPU_RESUME(resume),
		.POWER_MODE(mode));
	wake_source_model src (.clk(clk), .events(ev));

	////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// All bus tasks start and end at a falling edge
	// Whole byte each time, never read-modify-write
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = v;
		@(negedge clk);
		req.wr = 1'b0;
	endtask : wr

	task automatic rd(output logic [7:0] v);
		req.rd = 1'b1;
		req.addr = ADR;
		@(negedge clk);
		req.rd = 1'b0;
		v = rdata;
	endtask : rd

	task automatic wait_mode(input logic [1:0] m);
		int n;
		n = 0;
		while (mode !== m && n < 50) begin
			@(negedge clk);
			n++;
		end
		chk({6'h00, mode}, {6'h00, m});
	endtask : wait_mode

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(8'(mode), 8'(pwr_wake_pkg::MODE_NORMAL));
		chk({2'h0, gate, osc_off, reg_off, ram_bat, hold, ana_bat}, 8'h00);
		chk({6'h00, lp_osc, cmp_pwr}, 8'h03);
		rd(d);
		chk(d, 8'h00);
	endtask : t_reset

	task automatic t_suspend;
		wr(ADR, 8'h44);
		@(negedge clk);
		chk(8'(mode), 8'(pwr_wake_pkg::MODE_SUSPEND));
		chk({6'h00, gate, osc_off}, 8'h03);
		chk(8'(lp_osc), 8'h00);
		fork
			src.fire(pwr_wake_pkg::RTC_ALARM_BIT, 3);
		join_none
		wait_mode(pwr_wake_pkg::MODE_NORMAL);
		// Resume pulse stands only in the first cycle back
		chk(8'(resume), 8'h01);
		chk({6'h00, gate, osc_off}, 8'h00);
		rd(d);
		chk(d, 8'h00);
		repeat (3) @(negedge clk);
		rd(d);
		chk(d, 8'h04);
		chk(8'(lp_osc), 8'h01);
	endtask : t_suspend

	task automatic t_block;
		wr(ADR, 8'h84);
		@(negedge clk);
		chk(8'(mode), 8'(pwr_wake_pkg::MODE_NORMAL));
		chk(8'(reg_off), 8'h00);
		// Clear aimed at a neighbouring address must not land
		wr(8'hB4, 8'h20);
		rd(d);
		chk(d, 8'h04);
		wr(ADR, 8'h20);
		rd(d);
		chk(d, 8'h00);
	endtask : t_block

	task automatic t_sleep;
		wr(ADR, 8'h82);
		@(negedge clk);
		chk(8'(mode), 8'(pwr_wake_pkg::MODE_SLEEP));
		chk({6'h00, reg_off, ram_bat}, 8'h03);
		chk(8'(hold), 8'h01);
		chk({6'h00, ana_bat, cmp_pwr}, 8'h01);
		src.fire(pwr_wake_pkg::RTC_OSC_FAIL_BIT, 0);
		repeat (4) @(negedge clk);
		chk(8'(mode), 8'(pwr_wake_pkg::MODE_SLEEP));
		chk(8'(lp_osc), 8'h01);
		fork
			src.fire(pwr_wake_pkg::PORT_MATCH_BIT, 1);
		join_none
		wait_mode(pwr_wake_pkg::MODE_NORMAL);
		chk(8'(hold), 8'h00);
		repeat (3) @(negedge clk);
		rd(d);
		chk(d, 8'h0A);
		wr(ADR, 8'h20);
	endtask : t_sleep

	task automatic t_one_cell;
		// Let the clear write retire before the next write starts
		@(negedge clk);
		two_cell = 1'b0;
		for (int f = 0; f < 2; f++) begin
			flt = f[0];
			wr(ADR, 8'h81);
			@(negedge clk);
			chk({7'h00, ana_bat}, {7'h00, ~flt});
			chk(8'(cmp_pwr), 8'h00);
			src.fire(pwr_wake_pkg::COMPARATOR_BIT, 0);
			repeat (4) @(negedge clk);
			chk(8'(mode), 8'(pwr_wake_pkg::MODE_SLEEP));
			fork
				src.fire(pwr_wake_pkg::RESET_PIN_WAKE_BIT, 1);
			join_none
			wait_mode(pwr_wake_pkg::MODE_NORMAL);
			repeat (3) @(negedge clk);
			rd(d);
			chk(d, 8'h11);
			wr(ADR, 8'h20);
			// Give a real pin reset its chance before re-entry
			repeat (pwr_wake_pkg::RESET_HOLD_CLOCKS) @(negedge clk);
		end
		two_cell = 1'b1;
		flt = 1'b0;
	endtask : t_one_cell

	task automatic t_comp_wake;
		wr(ADR, 8'h89);
		@(negedge clk);
		chk(8'(mode), 8'(pwr_wake_pkg::MODE_SLEEP));
		chk(8'(cmp_pwr), 8'h01);
		fork
			src.fire(pwr_wake_pkg::COMPARATOR_BIT, 1);
		join_none
		wait_mode(pwr_wake_pkg::MODE_NORMAL);
		repeat (3) @(negedge clk);
		rd(d);
		chk(d, 8'h01);
		wr(ADR, 8'h20);
	endtask : t_comp_wake

	// Reset in mid-run must drop flags that were standing
	task automatic t_mid_reset;
		src.fire(pwr_wake_pkg::RTC_ALARM_BIT, 0);
		rd(d);
		chk(d, 8'h04);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk(8'(lp_osc), 8'h01);
		rd(d);
		chk(d, 8'h00);
	endtask : t_mid_reset

	////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		err_count++;
		close_out();
	end

	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_reset();
		t_suspend();
		t_block();
		t_sleep();
		t_one_cell();
		t_comp_wake();
		t_mid_reset();
		close_out();
	end
endmodule : power_unit_tb

// ---- tb/wake_source_model.sv ----
`timescale 1ns/1ps
// Event sources seen by the power unit: rtc fail and alarm, port match,
// comparator and the reset pin. The reset pin idles high and is pulled up.
module wake_source_model (
	input wire logic clk,
	output pwr_wake_pkg::wake_events_t events
);
	logic [4:0] lvl = 5'h10;

	assign events = pwr_wake_pkg::wake_events_t'(lvl);

	////////////////////////////////////////////////////////////////////////
	// One event: rising edge for the sources, falling edge for the pin
	task automatic fire(input int idx, input int lead);
		repeat (lead) @(negedge clk);
		lvl[idx] = ~lvl[idx];
		// Held long enough for the two-flop sync to catch it
		repeat (5) @(negedge clk);
		lvl[idx] = ~lvl[idx];
	endtask : fire
endmodule : wake_source_model
